// ===== design/lopa_alarm.sv
// Purpose: Low oil pressure warning with qualification, acknowledge and reminder tone.
// Assumes: All inputs synchronous to CORE_CLK; pressure and setpoint in the same units.
// Notes: Outputs are requests only; nothing here touches engine control.
module lopa_alarm #(
   parameter int PRESS_W = lopa_pkg::PRESS_W,
   parameter longint QUAL_CYCLES = lopa_pkg::QUAL_CYCLES,
   parameter longint ACK_CYCLES = lopa_pkg::ACK_CYCLES,
   parameter longint REMIND_PERIOD_CYCLES = lopa_pkg::REMIND_PERIOD_CYCLES,
   parameter longint REMIND_TONE_CYCLES = lopa_pkg::REMIND_TONE_CYCLES
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic SRST,
   // Measurement and configuration
   input wire logic [PRESS_W-1:0] PRESSURE,
   input wire logic PRESSURE_VALID,
   input wire logic [PRESS_W-1:0] SETPOINT,
   input wire logic ALARM_ENABLE,
   input wire logic ENGINE_RUNNING,
   // Operator button
   input wire logic MODE_BUTTON,
   // Requests
   output logic WARNING_ACTIVE,
   output logic OVERLAY_REQ,
   output logic TONE_REQ
);
   localparam int CW = lopa_pkg::CNT_W;
   localparam int PW = PRESS_W + 11;

   lopa_pkg::lopa_state_t state;
   lopa_pkg::lopa_state_t next_state;
   logic armed;
   logic under_margin;
   logic over_margin;
   logic raise_done;
   logic clear_done;
   logic ack_done;
   logic [CW-1:0] remind_cnt;
   logic remind_tone;

   // Scales a value by a per-mil factor, widened so no product overflows.
   function automatic logic [PW-1:0] scale(input logic [PRESS_W-1:0] v, input int permil);
      scale = PW'(v) * PW'(permil);
   endfunction

   assign armed = ALARM_ENABLE && ENGINE_RUNNING && PRESSURE_VALID;

   assign under_margin = armed && (scale(PRESSURE, lopa_pkg::PERMIL_BASE) <=
      scale(SETPOINT, lopa_pkg::PERMIL_BASE - lopa_pkg::RAISE_MARGIN_PERMIL));
   assign over_margin = armed && (scale(PRESSURE, lopa_pkg::PERMIL_BASE) >=
      scale(SETPOINT, lopa_pkg::PERMIL_BASE + lopa_pkg::CLEAR_MARGIN_PERMIL));

   lopa_timer #(.CNT_W(CW)) u_raise (
      .clk(CORE_CLK),
      .srst(SRST),
      .cond(under_margin && state == lopa_pkg::LOPA_IDLE),
      .limit(CW'(QUAL_CYCLES)),
      .expired(raise_done)
   );
   lopa_timer #(.CNT_W(CW)) u_clear (
      .clk(CORE_CLK),
      .srst(SRST),
      .cond(over_margin && state != lopa_pkg::LOPA_IDLE),
      .limit(CW'(QUAL_CYCLES)),
      .expired(clear_done)
   );
   lopa_timer #(.CNT_W(CW)) u_ack (
      .clk(CORE_CLK),
      .srst(SRST),
      .cond(MODE_BUTTON && state == lopa_pkg::LOPA_ALERT),
      .limit(CW'(ACK_CYCLES)),
      .expired(ack_done)
   );

   always_comb begin
      next_state = state;
      case (state)
         lopa_pkg::LOPA_IDLE: begin
            if (raise_done) begin
               next_state = lopa_pkg::LOPA_ALERT;
            end
         end
         lopa_pkg::LOPA_ALERT: begin
            if (clear_done) begin
               next_state = lopa_pkg::LOPA_IDLE;
            end else if (ack_done) begin
               next_state = lopa_pkg::LOPA_ACKED;
            end
         end
         lopa_pkg::LOPA_ACKED: begin
            if (clear_done) begin
               next_state = lopa_pkg::LOPA_IDLE;
            end
         end
         default: next_state = lopa_pkg::LOPA_IDLE;
      endcase
      if (!ALARM_ENABLE || !PRESSURE_VALID) begin
         next_state = lopa_pkg::LOPA_IDLE;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         state <= lopa_pkg::LOPA_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST || state != lopa_pkg::LOPA_ACKED) begin
         remind_cnt <= '0;
         remind_tone <= 1'b0;
      end else if (remind_cnt == CW'(REMIND_PERIOD_CYCLES - 1)) begin
         remind_cnt <= '0;
         remind_tone <= 1'b1;
      end else begin
         remind_cnt <= remind_cnt + 1'b1;
         if (remind_cnt == CW'(REMIND_TONE_CYCLES - 1)) begin
            remind_tone <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         WARNING_ACTIVE <= 1'b0;
         OVERLAY_REQ <= 1'b0;
         TONE_REQ <= 1'b0;
      end else begin
         WARNING_ACTIVE <= (next_state != lopa_pkg::LOPA_IDLE);
         OVERLAY_REQ <= (next_state == lopa_pkg::LOPA_ALERT);
         // The burst drops on the edge that clears remind_tone, so it lasts the tone length and no longer.
         TONE_REQ <= (next_state == lopa_pkg::LOPA_ALERT) ||
            (next_state == lopa_pkg::LOPA_ACKED && state == lopa_pkg::LOPA_ACKED &&
             (remind_cnt == CW'(REMIND_PERIOD_CYCLES - 1) ||
              (remind_tone && remind_cnt != CW'(REMIND_TONE_CYCLES - 1))));
      end
   end

   a_overlay_clear: assert property (@(posedge CORE_CLK) disable iff (SRST)
      !WARNING_ACTIVE |-> !OVERLAY_REQ)
      else $error("Overlay without warning.");
   a_unacked_tone: assert property (@(posedge CORE_CLK) disable iff (SRST)
      OVERLAY_REQ |-> TONE_REQ && WARNING_ACTIVE)
      else $error("Unacknowledged warning lacks tone.");
   a_disable_quiet: assert property (@(posedge CORE_CLK) disable iff (SRST)
      !ALARM_ENABLE |=> !WARNING_ACTIVE && !TONE_REQ)
      else $error("Disabled alarm produced output.");
   a_no_sender: assert property (@(posedge CORE_CLK) disable iff (SRST)
      !PRESSURE_VALID |=> !WARNING_ACTIVE)
      else $error("Warning without valid sender.");
   a_raise_cause: assert property (@(posedge CORE_CLK) disable iff (SRST)
      $rose(WARNING_ACTIVE) |-> $past(raise_done))
      else $error("Warning raised without qualification.");
   a_clear_cause: assert property (@(posedge CORE_CLK) disable iff (SRST)
      $fell(WARNING_ACTIVE) && !$past(SRST) && $past(ALARM_ENABLE) && $past(PRESSURE_VALID) |-> $past(clear_done))
      else $error("Warning cleared without qualification.");
   a_ack_drop: assert property (@(posedge CORE_CLK) disable iff (SRST)
      $fell(OVERLAY_REQ) && WARNING_ACTIVE |-> $past(ack_done))
      else $error("Overlay dropped without acknowledge.");
   a_run_needed: assert property (@(posedge CORE_CLK) disable iff (SRST)
      !ENGINE_RUNNING |=> !raise_done && !clear_done)
      else $error("Threshold evaluated with engine stopped.");
   a_reset_idle: assert property (@(posedge CORE_CLK)
      SRST |=> !WARNING_ACTIVE && !OVERLAY_REQ && !TONE_REQ)
      else $error("Outputs active after reset.");

   // Acknowledge seen while the unacknowledged warning still stands and nothing else overrides it.
   sequence s_ack_seen;
      ack_done && state == lopa_pkg::LOPA_ALERT && !clear_done && ALARM_ENABLE && PRESSURE_VALID;
   endsequence
   sequence s_acked_quiet;
      WARNING_ACTIVE && !OVERLAY_REQ && !TONE_REQ;
   endsequence

   a_ack_silence: assert property (@(posedge CORE_CLK) disable iff (SRST)
      s_ack_seen |=> s_acked_quiet)
      else $error("Acknowledge did not silence the warning.");
   a_clear_withdraw: assert property (@(posedge CORE_CLK) disable iff (SRST)
      clear_done |=> !WARNING_ACTIVE && !OVERLAY_REQ && !TONE_REQ)
      else $error("Cleared warning left a request standing.");
   a_tone_warning: assert property (@(posedge CORE_CLK) disable iff (SRST)
      TONE_REQ |-> WARNING_ACTIVE)
      else $error("Tone without a warning.");
   a_margin_restart: assert property (@(posedge CORE_CLK) disable iff (SRST)
      !under_margin |=> !raise_done)
      else $error("Raise qualified across a break in the margin.");

   // Length of the running reminder burst; it exists only so the check below can bound it.
   logic [CW-1:0] tone_run;
   always_ff @(posedge CORE_CLK) begin
      if (SRST || !TONE_REQ || OVERLAY_REQ) begin
         tone_run <= '0;
      end else begin
         tone_run <= tone_run + 1'b1;
      end
   end
   a_remind_length: assert property (@(posedge CORE_CLK) disable iff (SRST)
      tone_run <= CW'(REMIND_TONE_CYCLES))
      else $error("Reminder tone ran too long.");
endmodule

// ===== design/lopa_pkg.sv
// Purpose: Shared constants for the low oil pressure alarm.
// Assumes: 50 MHz core clock.
// Notes: Times are kept in their own units; cycle counts derive from them.
package lopa_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int QUAL_TIME_S = 10;
   localparam int ACK_TIME_S = 1;
   localparam int REMIND_PERIOD_S = 300;
   localparam int REMIND_TONE_S = 2;
   localparam longint QUAL_CYCLES = longint'(QUAL_TIME_S) * CLK_HZ;
   localparam longint ACK_CYCLES = longint'(ACK_TIME_S) * CLK_HZ;
   localparam longint REMIND_PERIOD_CYCLES = longint'(REMIND_PERIOD_S) * CLK_HZ;
   localparam longint REMIND_TONE_CYCLES = longint'(REMIND_TONE_S) * CLK_HZ;
   // Raise margin 0.4 percent and clear margin 2 percent, in tenths of a percent.
   localparam int RAISE_MARGIN_PERMIL = 4;
   localparam int CLEAR_MARGIN_PERMIL = 20;
   localparam int PERMIL_BASE = 1000;
   localparam int PRESS_W = 16;
   localparam int CNT_W = 36;
   typedef enum logic [2:0] {
      LOPA_IDLE = 3'b001,
      LOPA_ALERT = 3'b010,
      LOPA_ACKED = 3'b100
   } lopa_state_t;
endpackage

// ===== design/lopa_timer.sv
// Purpose: Qualification timer; pulses once a condition has held longer than a limit.
// Assumes: Limit is at least one cycle.
// Notes: Dropping the condition restarts the count at zero.
module lopa_timer #(
   parameter int CNT_W = 36
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Condition and limit
   input wire logic cond,
   input wire logic [CNT_W-1:0] limit,
   // Result
   output logic expired
);
   logic [CNT_W-1:0] count;

   always_ff @(posedge clk) begin
      if (srst || !cond) begin
         count <= '0;
         expired <= 1'b0;
      end else if (count <= limit) begin
         count <= count + 1'b1;
         expired <= (count == limit);
      end else begin
         expired <= 1'b0;
      end
   end
endmodule

// ===== sim/lopa_alarm_tb.sv
// Purpose: Self-checking bench for the low oil pressure alarm.
// Assumes: Short timing parameters stand in for the seconds and minutes.
// Notes: Pressures derive from a random setpoint, so each margin holds for any setpoint drawn.
module lopa_alarm_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam longint QUAL = 20;
   localparam longint ACK = 5;
   localparam longint REM_P = 100;
   localparam longint REM_T = 10;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] pressure = 16'h0000;
   logic [15:0] setpoint = 16'h0000;
   logic pressure_valid = 1'b1;
   logic alarm_enable = 1'b1;
   logic engine_running = 1'b0;
   logic mode_button = 1'b0;
   logic warning_active;
   logic overlay_req;
   logic tone_req;
   wire [2:0] outs;
   int num_errors = 0;
   int comparisons = 0;
   logic [15:0] sp;

   assign outs = {warning_active, overlay_req, tone_req};
   always #10 core_clk = ~core_clk;

   lopa_alarm #(.PRESS_W(16), .QUAL_CYCLES(QUAL), .ACK_CYCLES(ACK), .REMIND_PERIOD_CYCLES(REM_P),
      .REMIND_TONE_CYCLES(REM_T)) dut_u (.CORE_CLK(core_clk), .SRST(srst), .PRESSURE(pressure),
      .PRESSURE_VALID(pressure_valid), .SETPOINT(setpoint), .ALARM_ENABLE(alarm_enable),
      .ENGINE_RUNNING(engine_running), .MODE_BUTTON(mode_button), .WARNING_ACTIVE(warning_active),
      .OVERLAY_REQ(overlay_req), .TONE_REQ(tone_req));

   // One below the raise margin and one above the clear margin, rounded safely.
   function automatic logic [15:0] low_p(input logic [15:0] s);
      return 16'((32'(s) * 996) / 1000 - 1);
   endfunction
   function automatic logic [15:0] high_p(input logic [15:0] s);
      return 16'((32'(s) * 1020) / 1000 + 1);
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d, errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %b, seen %b", name, exp, seen);
      end
   endtask
   task automatic put(input logic [15:0] p, input logic en, input logic run, input logic vld, input logic btn);
      @(posedge core_clk);
      pressure <= p;
      alarm_enable <= en;
      engine_running <= run;
      pressure_valid <= vld;
      mode_button <= btn;
   endtask
   task automatic hold_outs(input logic [2:0] exp, input longint n);
      repeat (n) begin
         @(negedge core_clk);
         check("outputs held", outs, exp);
      end
   endtask
   // Bounded wait; running out of cycles is a mismatch and ends the run.
   task automatic wait_outs(input logic [2:0] exp, input longint n);
      for (longint i = 0; i < n; i++) begin
         @(negedge core_clk);
         if (outs === exp) break;
      end
      check("outputs reached", outs, exp);
      if (outs !== exp) end_of_test();
   endtask

   initial begin
      void'($urandom(88098));
      sp = 16'(1000 + $urandom_range(59000));
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      setpoint <= sp;
      pressure <= sp;
      hold_outs(3'b000, 3);
      put(low_p(sp), 1'b1, 1'b0, 1'b1, 1'b0);
      hold_outs(3'b000, 40);
      put(low_p(sp), 1'b1, 1'b1, 1'b1, 1'b0);
      hold_outs(3'b000, 15);
      put(sp, 1'b1, 1'b1, 1'b1, 1'b0);
      put(low_p(sp), 1'b1, 1'b1, 1'b1, 1'b0);
      hold_outs(3'b000, QUAL);
      wait_outs(3'b111, 10);
      put(low_p(sp), 1'b1, 1'b1, 1'b1, 1'b1);
      hold_outs(3'b111, 3);
      put(low_p(sp), 1'b1, 1'b1, 1'b1, 1'b0);
      hold_outs(3'b111, 10);
      put(low_p(sp), 1'b1, 1'b1, 1'b1, 1'b1);
      wait_outs(3'b100, ACK + 8);
      put(low_p(sp), 1'b1, 1'b1, 1'b1, 1'b0);
      // The first reminder comes one full period after the acknowledge and lasts exactly the tone length.
      hold_outs(3'b100, REM_P - 1);
      wait_outs(3'b101, 3);
      hold_outs(3'b101, REM_T - 1);
      hold_outs(3'b100, 20);
      put(sp, 1'b1, 1'b1, 1'b1, 1'b0);
      hold_outs(3'b100, 40);
      put(high_p(sp), 1'b1, 1'b1, 1'b1, 1'b0);
      hold_outs(3'b100, QUAL);
      wait_outs(3'b000, 10);
      for (int k = 0; k < 2; k++) begin
         sp = 16'(1000 + $urandom_range(59000));
         @(posedge core_clk);
         setpoint <= sp;
         put(low_p(sp), 1'b1, 1'b1, 1'b1, 1'b0);
         wait_outs(3'b111, QUAL + 10);
         put(low_p(sp), k[0], 1'b1, ~k[0], 1'b0);
         wait_outs(3'b000, 3);
         hold_outs(3'b000, 30);
      end
      put(low_p(sp), 1'b1, 1'b1, 1'b1, 1'b0);
      wait_outs(3'b111, QUAL + 10);
      @(posedge core_clk);
      srst <= 1'b1;
      wait_outs(3'b000, 3);
      @(posedge core_clk);
      srst <= 1'b0;
      hold_outs(3'b000, QUAL);
      wait_outs(3'b111, 10);
      // A stopped engine freezes evaluation but leaves the standing warning in place.
      put(low_p(sp), 1'b1, 1'b0, 1'b1, 1'b0);
      hold_outs(3'b111, QUAL + 5);
      put(high_p(sp), 1'b1, 1'b1, 1'b1, 1'b0);
      wait_outs(3'b000, QUAL + 10);
      end_of_test();
   end
endmodule
